// File: design/asr_ctl.sv
// asr_ctl: converter input source, reference, amplifier and clock control.
// assumes a synchronous 8-bit register port with read data one cycle later.
//
// Functional notes
// - source codes 0000, 0100, 1100-1111 route the chosen external pin
// - codes 0001-0011 pick supply, supply/2, supply/4
// - codes 0101-0111 pick amplified ref, /2, /4
// - codes 10xx tie the converter input to ground
// - internal source opens every external pin switch
// - external channel codes 1001-1111 select no pin, input floats
// - bit 3 of input/clock register reads zero
// - conversion clock is system clock divided by 2**code
// - bits 6 and 5 of reference register read zero
// - amplifier input from ref pin or bandgap; bandgap opens the pin
// - reference: 00 supply, 01 pin, 1x amplified ref
// - supply or amplified reference opens the reference pin
// - gain code 00..11 gives 1, 1.667, 2.5, 3.333
// - bandgap register holds only enable in bit 0, resets to 0
// - analog pin overrides direction, other functions and pull-high
// - channel codes pick pins 0, 1, 3-8; 0010, 1001-1011 reserved
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
module asr_ctl import asr_pkg::*; (
    input wire logic clk_sys, // system clock, 100 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic [3:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    input wire logic [ASR_NUM_PINS-1:0] pin_is_analog, // from pin function selects
    output logic [2:0] conv_src, // converter input source code
    output logic conv_gnd, // converter input tied to ground
    output logic [ASR_NUM_PINS-1:0] analog_input_pin_sw, // pin switches
    output logic [ASR_NUM_PINS-1:0] pin_dir_override, // direction override
    output logic [ASR_NUM_PINS-1:0] pin_func_off, // other functions off
    output logic [ASR_NUM_PINS-1:0] pin_pullup_off, // pull-high off
    output logic [1:0] conv_ref, // reference choice
    output logic ext_ref_pin_sw, // reference pin switch
    output logic gain_amp_en, // amplifier power
    output logic gain_amp_ref_pin_sw, // amplifier ref pin switch
    output logic gain_amp_bg_sw, // amplifier from bandgap
    output logic [1:0] gain_amp_gain_sel, // gain code
    output logic bandgap_en, // bandgap power
    output logic conv_clk // conversion clock
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] chan_reg;
    logic [7:0] input_clock_select_reg;
    logic [7:0] reference_control_reg;
    logic [7:0] bandgap_control_reg;

    wire wr_chan = reg_wr && (reg_addr == ASR_OFF_CHAN);
    wire wr_ics = reg_wr && (reg_addr == ASR_OFF_ICS);
    wire wr_ref = reg_wr && (reg_addr == ASR_OFF_REF);
    wire wr_bg = reg_wr && (reg_addr == ASR_OFF_BG);

    // masks keep unimplemented bits at zero so reads need no extra gating
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chan_reg <= ASR_RST_VAL;
            input_clock_select_reg <= ASR_RST_VAL;
            reference_control_reg <= ASR_RST_VAL;
            bandgap_control_reg <= ASR_RST_VAL;
        end else begin
            if (wr_chan) begin
                chan_reg <= reg_wdata & ASR_MASK_CHAN;
            end
            if (wr_ics) begin
                input_clock_select_reg <= reg_wdata & ASR_MASK_ICS;
            end
            if (wr_ref) begin
                reference_control_reg <= reg_wdata & ASR_MASK_REF;
            end
            if (wr_bg) begin
                bandgap_control_reg <= reg_wdata & ASR_MASK_BG;
            end
        end
    end

    // ************************************************************
    // field decode
    // ************************************************************
    wire [3:0] input_source_sel = input_clock_select_reg[ASR_SRC_LSB +: 4];
    wire [2:0] conv_clk_div_sel = input_clock_select_reg[ASR_DIV_LSB +: 3];
    wire [3:0] ext_channel_sel = chan_reg[3:0];
    wire gain_amp_input_sel = reference_control_reg[ASR_AMP_IN_BIT];
    wire [1:0] ref_source_sel = reference_control_reg[ASR_REF_LSB +: 2];

    asr_src_t next_src;
    always_comb begin
        if (input_source_sel[3:2] == 2'b10) begin
            next_src = ASR_SRC_GND;
        end else if (input_source_sel[1:0] == 2'b00 || input_source_sel[3]) begin
            next_src = ASR_SRC_EXT;
        end else if (!input_source_sel[2]) begin
            next_src = asr_src_t'({1'b0, input_source_sel[1:0]});
        end else begin
            next_src = asr_src_t'({1'b0, input_source_sel[1:0]} + 3'h3);
        end
    end

    wire ext_route = (next_src == ASR_SRC_EXT);
    wire [1:0] next_ref = ref_source_sel[1] ? 2'(ASR_REF_AMP) : ref_source_sel;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            conv_src <= 3'(ASR_SRC_EXT);
            conv_gnd <= 1'b0;
            conv_ref <= 2'(ASR_REF_SUP);
            ext_ref_pin_sw <= 1'b0;
            gain_amp_en <= 1'b0;
            gain_amp_ref_pin_sw <= 1'b0;
            gain_amp_bg_sw <= 1'b0;
            gain_amp_gain_sel <= 2'h0;
            bandgap_en <= 1'b0;
        end else begin
            conv_src <= 3'(next_src);
            conv_gnd <= (next_src == ASR_SRC_GND);
            conv_ref <= next_ref;
            ext_ref_pin_sw <= (next_ref == 2'(ASR_REF_PIN));
            gain_amp_en <= reference_control_reg[ASR_AMP_EN_BIT];
            gain_amp_ref_pin_sw <= !gain_amp_input_sel;
            gain_amp_bg_sw <= gain_amp_input_sel;
            gain_amp_gain_sel <= reference_control_reg[ASR_GAIN_LSB +: 2];
            bandgap_en <= bandgap_control_reg[ASR_BG_EN_BIT];
        end
    end

    // ************************************************************
    // submodules
    // ************************************************************
    asr_pin_ctl u_pins (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ext_route(ext_route),
        .ext_channel_sel(ext_channel_sel),
        .pin_is_analog(pin_is_analog),
        .analog_input_pin_sw(analog_input_pin_sw),
        .pin_dir_override(pin_dir_override),
        .pin_func_off(pin_func_off),
        .pin_pullup_off(pin_pullup_off)
    );

    asr_clk_div u_div (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .div_sel(conv_clk_div_sel),
        .conv_clk(conv_clk)
    );

    // ************************************************************
    // read port
    // ************************************************************
    // status shows ground, reference, ref pin and bandgap switches and source right now; pin switches are not in it
    wire [7:0] stat_word = {conv_gnd, conv_ref, ext_ref_pin_sw, gain_amp_bg_sw, conv_src};
    logic [7:0] next_rdata;
    always_comb begin
        if (reg_addr == ASR_OFF_CHAN) begin
            next_rdata = chan_reg;
        end else if (reg_addr == ASR_OFF_ICS) begin
            next_rdata = input_clock_select_reg;
        end else if (reg_addr == ASR_OFF_REF) begin
            next_rdata = reference_control_reg;
        end else if (reg_addr == ASR_OFF_BG) begin
            next_rdata = bandgap_control_reg;
        end else if (reg_addr == ASR_OFF_STAT) begin
            next_rdata = stat_word;
        end else begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_ics_bit3;
        @(posedge clk_sys) disable iff (!rst_n)
        reg_rd && reg_addr == ASR_OFF_ICS |=> !reg_rdata[3];
    endproperty
    a_ics_bit3: assert property (p_ics_bit3) else $error("bit 3 reads one");

    property p_ref_bits;
        @(posedge clk_sys) disable iff (!rst_n)
        reg_rd && reg_addr == ASR_OFF_REF |=> reg_rdata[6:5] == 2'h0;
    endproperty
    a_ref_bits: assert property (p_ref_bits) else $error("bits 6:5 read nonzero");

    property p_bg_write;
        @(posedge clk_sys) disable iff (!rst_n)
        wr_bg ##1 reg_rd && reg_addr == ASR_OFF_BG |=> reg_rdata == {7'h00, $past(reg_wdata[0], 2)};
    endproperty
    a_bg_write: assert property (p_bg_write) else $error("bandgap register readback wrong");

    property p_gnd;
        @(posedge clk_sys) disable iff (!rst_n)
        input_source_sel[3:2] == 2'b10 |=> conv_gnd && analog_input_pin_sw == '0;
    endproperty
    a_gnd: assert property (p_gnd) else $error("ground code not grounded");

    property p_sup4;
        @(posedge clk_sys) disable iff (!rst_n)
        input_source_sel == 4'h3 |=> conv_src == 3'(ASR_SRC_SUP4) && !conv_gnd;
    endproperty
    a_sup4: assert property (p_sup4) else $error("supply/4 not routed");

    property p_amp2;
        @(posedge clk_sys) disable iff (!rst_n)
        input_source_sel == 4'h6 |=> conv_src == 3'(ASR_SRC_AMP2);
    endproperty
    a_amp2: assert property (p_amp2) else $error("amplified/2 not routed");

    property p_ref_pin;
        @(posedge clk_sys) disable iff (!rst_n)
        ref_source_sel != 2'b01 |=> !ext_ref_pin_sw;
    endproperty
    a_ref_pin: assert property (p_ref_pin) else $error("reference pin left connected");

    property p_bg_opens_pin;
        @(posedge clk_sys) disable iff (!rst_n)
        gain_amp_input_sel |=> gain_amp_bg_sw && !gain_amp_ref_pin_sw;
    endproperty
    a_bg_opens_pin: assert property (p_bg_opens_pin) else $error("amp ref pin not opened");

    // fixed codes here, so a broken decode cannot agree with itself
    property p_ext_src;
        @(posedge clk_sys) disable iff (!rst_n)
        input_source_sel == 4'hc |=> conv_src == 3'(ASR_SRC_EXT) && !conv_gnd;
    endproperty
    a_ext_src: assert property (p_ext_src) else $error("external code not routed");

    property p_sup;
        @(posedge clk_sys) disable iff (!rst_n)
        input_source_sel == 4'h1 |=> conv_src == 3'(ASR_SRC_SUP);
    endproperty
    a_sup: assert property (p_sup) else $error("supply not routed");

    property p_amp;
        @(posedge clk_sys) disable iff (!rst_n)
        input_source_sel == 4'h5 |=> conv_src == 3'(ASR_SRC_AMP);
    endproperty
    a_amp: assert property (p_amp) else $error("amplified ref not routed");

    property p_amp4;
        @(posedge clk_sys) disable iff (!rst_n)
        input_source_sel == 4'h7 |=> conv_src == 3'(ASR_SRC_AMP4);
    endproperty
    a_amp4: assert property (p_amp4) else $error("amplified/4 not routed");

    property p_int_pins;
        @(posedge clk_sys) disable iff (!rst_n)
        input_source_sel == 4'h2 |=> analog_input_pin_sw == '0;
    endproperty
    a_int_pins: assert property (p_int_pins) else $error("pin closed with internal source");

    property p_ref_amp;
        @(posedge clk_sys) disable iff (!rst_n)
        ref_source_sel[1] |=> conv_ref == 2'(ASR_REF_AMP) && !ext_ref_pin_sw;
    endproperty
    a_ref_amp: assert property (p_ref_amp) else $error("amplified reference not chosen");

    property p_ref_sel_pin;
        @(posedge clk_sys) disable iff (!rst_n)
        ref_source_sel == 2'b01 |=> conv_ref == 2'(ASR_REF_PIN) && ext_ref_pin_sw;
    endproperty
    a_ref_sel_pin: assert property (p_ref_sel_pin) else $error("reference pin not chosen");

    property p_amp_pin;
        @(posedge clk_sys) disable iff (!rst_n)
        !gain_amp_input_sel |=> gain_amp_ref_pin_sw && !gain_amp_bg_sw;
    endproperty
    a_amp_pin: assert property (p_amp_pin) else $error("amp not fed from ref pin");

    property p_gain;
        @(posedge clk_sys) disable iff (!rst_n)
        reference_control_reg[ASR_GAIN_LSB +: 2] == 2'h3 |=> gain_amp_gain_sel == 2'h3;
    endproperty
    a_gain: assert property (p_gain) else $error("gain code not applied");

    property p_bg_bits;
        @(posedge clk_sys) disable iff (!rst_n)
        reg_rd && reg_addr == ASR_OFF_BG |=> reg_rdata[7:1] == 7'h00;
    endproperty
    a_bg_bits: assert property (p_bg_bits) else $error("bandgap bits 7:1 read nonzero");

    c_gnd: cover property (@(posedge clk_sys) disable iff (!rst_n) conv_gnd);
    c_amp_ref: cover property (@(posedge clk_sys) disable iff (!rst_n) conv_ref == 2'(ASR_REF_AMP) && gain_amp_en);
    c_bg: cover property (@(posedge clk_sys) disable iff (!rst_n) bandgap_en && gain_amp_bg_sw);
endmodule : asr_ctl

// File: design/asr_pkg.sv
// asr_pkg: constants shared by the converter source, reference and clock control block.
// assumes a single 100 MHz system clock and an 8-bit register port.
package asr_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [3:0] ASR_OFF_CHAN = 4'h0; // holds ext_channel_sel
    localparam logic [3:0] ASR_OFF_ICS = 4'h1;  // input_clock_select_reg
    localparam logic [3:0] ASR_OFF_REF = 4'h2;  // reference_control_reg
    localparam logic [3:0] ASR_OFF_BG = 4'h3;   // bandgap_control_reg
    localparam logic [3:0] ASR_OFF_STAT = 4'h4; // read-only routing status

    localparam logic [7:0] ASR_RST_VAL = 8'h00;
    localparam logic [7:0] ASR_MASK_CHAN = 8'h0f;
    localparam logic [7:0] ASR_MASK_ICS = 8'hf7;
    localparam logic [7:0] ASR_MASK_REF = 8'h9f;
    localparam logic [7:0] ASR_MASK_BG = 8'h01;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int ASR_SRC_LSB = 4;
    localparam int ASR_DIV_LSB = 0;
    localparam int ASR_AMP_EN_BIT = 7;
    localparam int ASR_AMP_IN_BIT = 4;
    localparam int ASR_REF_LSB = 2;
    localparam int ASR_GAIN_LSB = 0;
    localparam int ASR_BG_EN_BIT = 0;

    localparam int ASR_NUM_PINS = 9;
    localparam int ASR_DIV_W = 7;

    typedef enum logic [2:0] {
        ASR_SRC_EXT,
        ASR_SRC_SUP,
        ASR_SRC_SUP2,
        ASR_SRC_SUP4,
        ASR_SRC_AMP,
        ASR_SRC_AMP2,
        ASR_SRC_AMP4,
        ASR_SRC_GND
    } asr_src_t;

    typedef enum logic [1:0] {
        ASR_REF_SUP,
        ASR_REF_PIN,
        ASR_REF_AMP
    } asr_ref_t;

endpackage : asr_pkg

// File: design/asr_clk_div.sv
// asr_clk_div: free-running divider making the conversion clock.
// assumes clk_sys is the system clock; output is a registered counter bit, or clk_sys itself for code 0.
`timescale 1ns/1ps
module asr_clk_div import asr_pkg::*; (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [2:0] div_sel, // ratio code, 2**code
    output logic conv_clk // divided clock
);
    logic [ASR_DIV_W-1:0] cnt;
    logic [ASR_DIV_W:0] ext_cnt;
    logic next_conv_clk;

    // code 0 passes clk_sys through untouched, the rest pick a counter bit
    assign ext_cnt = {cnt, 1'b0};
    assign next_conv_clk = ext_cnt[div_sel];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 7'h01;
        end
    end

    // divide-by-1 must follow the clock itself, so only that code is gated in
    assign conv_clk = (div_sel == 3'h0) ? clk_sys : next_conv_clk;

    // ************************************************************
    // checks
    // ************************************************************
    property p_div_toggle;
        @(posedge clk_sys) disable iff (!rst_n)
        (div_sel == 3'h1) ##1 (div_sel == 3'h1) |-> (conv_clk != $past(conv_clk));
    endproperty
    a_div_toggle: assert property (p_div_toggle) else $error("divide by 2 does not toggle");

    property p_div_128;
        @(posedge clk_sys) disable iff (!rst_n)
        (div_sel == 3'h7) && (cnt == 7'h3f) ##1 (div_sel == 3'h7) |-> conv_clk;
    endproperty
    a_div_128: assert property (p_div_128) else $error("divide by 128 phase wrong");

    c_div_128: cover property (@(posedge clk_sys) disable iff (!rst_n) div_sel == 3'h7 && cnt == 7'h7f);
endmodule : asr_clk_div

// File: design/asr_pin_ctl.sv
// asr_pin_ctl: per-pin analog switch and override controls.
// assumes each pin's function select marks it as a converter input.
`timescale 1ns/1ps
module asr_pin_ctl import asr_pkg::*; (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic ext_route, // external source chosen
    input wire logic [3:0] ext_channel_sel, // channel code
    input wire logic [ASR_NUM_PINS-1:0] pin_is_analog, // function select says analog
    output logic [ASR_NUM_PINS-1:0] analog_input_pin_sw, // pin switch closed
    output logic [ASR_NUM_PINS-1:0] pin_dir_override, // force port direction off
    output logic [ASR_NUM_PINS-1:0] pin_func_off, // other functions disabled
    output logic [ASR_NUM_PINS-1:0] pin_pullup_off // pull-high disconnected
);
    logic [ASR_NUM_PINS-1:0] next_sw;

    // code 0010 is reserved, so pin 2 never closes; 1001..1111 close nothing
    genvar i;
    generate
        for (i = 0; i < ASR_NUM_PINS; i++) begin : g_pin
            assign next_sw[i] = ext_route && (i != 2) && (ext_channel_sel == 4'(i));
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    analog_input_pin_sw[i] <= 1'b0;
                    pin_dir_override[i] <= 1'b0;
                    pin_func_off[i] <= 1'b0;
                    pin_pullup_off[i] <= 1'b0;
                end else begin
                    analog_input_pin_sw[i] <= next_sw[i];
                    pin_dir_override[i] <= pin_is_analog[i];
                    pin_func_off[i] <= pin_is_analog[i];
                    pin_pullup_off[i] <= pin_is_analog[i];
                end
            end
        end
    endgenerate

    property p_no_ext_when_internal;
        @(posedge clk_sys) disable iff (!rst_n)
        !ext_route |=> (analog_input_pin_sw == '0);
    endproperty
    a_no_ext_when_internal: assert property (p_no_ext_when_internal) else $error("pin joined to internal source");

    property p_float;
        @(posedge clk_sys) disable iff (!rst_n)
        ext_route && (ext_channel_sel >= 4'h9) |=> (analog_input_pin_sw == '0);
    endproperty
    a_float: assert property (p_float) else $error("pin closed for floating code");

    property p_pin_pick;
        @(posedge clk_sys) disable iff (!rst_n)
        ext_route && (ext_channel_sel == 4'h8) |=> analog_input_pin_sw[8] && $onehot(analog_input_pin_sw);
    endproperty
    a_pin_pick: assert property (p_pin_pick) else $error("pin 8 not selected alone");

    property p_override;
        @(posedge clk_sys) disable iff (!rst_n)
        pin_is_analog[0] |=> pin_pullup_off[0] && pin_func_off[0] && pin_dir_override[0];
    endproperty
    a_override: assert property (p_override) else $error("analog pin not overridden");

    c_ext_pin: cover property (@(posedge clk_sys) disable iff (!rst_n) analog_input_pin_sw[3]);
endmodule : asr_pin_ctl

// File: sim/testbench.sv
// testbench: self-checking bench for the converter source, reference and clock control block.
// assumes asr_pkg and asr_ctl are compiled first; drives the register port and pin selects directly.
`timescale 1ns/1ps
module testbench;
    import asr_pkg::*;

    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [ASR_NUM_PINS-1:0] pin_is_analog = '0;
    logic [7:0] reg_rdata;
    logic [2:0] conv_src;
    logic conv_gnd;
    logic [ASR_NUM_PINS-1:0] analog_input_pin_sw, pin_dir_override, pin_func_off, pin_pullup_off;
    logic [1:0] conv_ref, gain_amp_gain_sel;
    logic ext_ref_pin_sw, gain_amp_en, gain_amp_ref_pin_sw, gain_amp_bg_sw, bandgap_en, conv_clk;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] rd;

    always #5 clk_sys = ~clk_sys;

    asr_ctl i_asr_ctl (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_is_analog(pin_is_analog),
        .conv_src(conv_src), .conv_gnd(conv_gnd), .analog_input_pin_sw(analog_input_pin_sw),
        .pin_dir_override(pin_dir_override), .pin_func_off(pin_func_off), .pin_pullup_off(pin_pullup_off),
        .conv_ref(conv_ref), .ext_ref_pin_sw(ext_ref_pin_sw), .gain_amp_en(gain_amp_en),
        .gain_amp_ref_pin_sw(gain_amp_ref_pin_sw), .gain_amp_bg_sw(gain_amp_bg_sw),
        .gain_amp_gain_sel(gain_amp_gain_sel), .bandgap_en(bandgap_en), .conv_clk(conv_clk));

    // ************************************************************
    // reporting
    // ************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    // whole run is well under 5000 cycles; this only cuts a hang
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end

    // ************************************************************
    // register port
    // ************************************************************
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdreg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rdreg

    // decoded outputs follow the register one edge later
    task automatic settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : settle

    // ************************************************************
    // expected decode
    // ************************************************************
    function automatic logic is_ext(input logic [3:0] s);
        return (s == 4'h0) || (s == 4'h4) || (s >= 4'hc);
    endfunction : is_ext

    function automatic logic [8:0] exp_pins(input logic [3:0] s, input logic [3:0] c);
        if (!is_ext(s) || c == 4'h2 || c > 4'h8) return 9'h000;
        return 9'h001 << c;
    endfunction : exp_pins

    function automatic logic [2:0] exp_src(input logic [3:0] s);
        if (is_ext(s)) return 3'h0;
        if (s < 4'h4) return s[2:0];
        if (s < 4'h8) return 3'(s - 4'h1);
        return 3'h7;
    endfunction : exp_src

    // period of conv_clk in system cycles, sampled away from the edges
    task automatic measure(input int k);
        int first;
        int n;
        logic prev;
        first = -1;
        wr(ASR_OFF_ICS, 8'(k));
        settle();
        @(negedge clk_sys);
        prev = conv_clk;
        for (n = 0; n < 300; n++) begin
            @(negedge clk_sys);
            if (!prev && conv_clk) begin
                if (first < 0) first = n;
                else break;
            end
            prev = conv_clk;
        end
        check(16'(n - first), 16'(1 << k));
    endtask : measure

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        int s;
        int c;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (s = 0; s < 6; s++) begin
            rdreg(4'(s), rd);
            check(16'(rd), 16'(ASR_RST_VAL));
        end
        // unimplemented bits dropped, unmapped place ignored
        wr(ASR_OFF_CHAN, 8'hff);
        wr(ASR_OFF_ICS, 8'hff);
        wr(ASR_OFF_BG, 8'hff);
        wr(ASR_OFF_REF, 8'hff);
        wr(4'h9, 8'hff);
        rdreg(ASR_OFF_CHAN, rd);
        check(16'(rd), 16'h000f);
        rdreg(ASR_OFF_ICS, rd);
        check(16'(rd), 16'h00f7);
        rdreg(ASR_OFF_REF, rd);
        check(16'(rd), 16'h009f);
        rdreg(ASR_OFF_BG, rd);
        check(16'(rd), 16'h0001);
        rdreg(4'h9, rd);
        check(16'(rd), 16'h0000);
        check(16'(bandgap_en), 16'h0001);
        wr(ASR_OFF_BG, 8'hfe);
        settle();
        check(16'(bandgap_en), 16'h0000);
        // bandgap back on before it feeds the amplifier; write and read with no gap
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= ASR_OFF_BG;
        reg_wdata <= 8'h01;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        check(16'(reg_rdata), 16'h0001);
        repeat (64) @(posedge clk_sys);
        // reference, amplifier input and gain; amplifier on while its output is used
        for (s = 0; s < 4; s++) begin
            wr(ASR_OFF_REF, 8'h60 | 8'((s & 1) << 4) | 8'(s << 2) | 8'(s) | ((s >= 2) ? 8'h80 : 8'h00));
            settle();
            check(16'(conv_ref), (s < 2) ? 16'(s) : 16'h0002);
            check(16'(ext_ref_pin_sw), (s == 1) ? 16'h0001 : 16'h0000);
            check(16'({gain_amp_bg_sw, gain_amp_ref_pin_sw}), s[0] ? 16'h0002 : 16'h0001);
            check(16'(gain_amp_gain_sel), 16'(s));
            check(16'(gain_amp_en), (s >= 2) ? 16'h0001 : 16'h0000);
            rdreg(ASR_OFF_STAT, rd);
            check(16'(rd), 16'({1'b0, (s < 2) ? 2'(s) : 2'h2, s == 1, s[0], 3'h0}));
        end
        wr(ASR_OFF_REF, 8'h80);
        settle();
        check(16'(gain_amp_en), 16'h0001);
        // every source code against an external channel that would close pin 5
        wr(ASR_OFF_CHAN, 8'h05);
        for (s = 0; s < 16; s++) begin
            wr(ASR_OFF_ICS, 8'(s << 4));
            settle();
            check(16'(conv_src), 16'(exp_src(4'(s))));
            check(16'(conv_gnd), (s >= 8 && s < 12) ? 16'h0001 : 16'h0000);
            check(16'(analog_input_pin_sw), 16'(exp_pins(4'(s), 4'h5)));
            rdreg(ASR_OFF_STAT, rd);
            check(16'(rd), 16'({(s >= 8 && s < 12), 4'h0, exp_src(4'(s))}));
        end
        // every channel code under two external source codes
        for (s = 0; s < 2; s++) begin
            wr(ASR_OFF_ICS, s ? 8'hc0 : 8'h40);
            for (c = 0; c < 16; c++) begin
                wr(ASR_OFF_CHAN, 8'(c));
                settle();
                check(16'(analog_input_pin_sw), 16'(exp_pins(4'h4, 4'(c))));
            end
        end
        // pin function select overrides
        @(posedge clk_sys);
        pin_is_analog <= 9'h1a5;
        settle();
        check(16'(pin_dir_override), 16'h01a5);
        check(16'(pin_func_off), 16'h01a5);
        check(16'(pin_pullup_off), 16'h01a5);
        @(posedge clk_sys);
        pin_is_analog <= 9'h05a;
        settle();
        check(16'({pin_dir_override & pin_func_off & pin_pullup_off}), 16'h005a);
        // divider: code 0 passes the system clock
        wr(ASR_OFF_ICS, 8'h00);
        settle();
        #1;
        check(16'(conv_clk), 16'h0001);
        @(negedge clk_sys);
        #2;
        check(16'(conv_clk), 16'h0000);
        for (s = 1; s < 8; s++) begin
            measure(s);
        end
        measure(2);
        wrap_up();
    end

endmodule : testbench
